// File: bench/playback_volume_pdm_config_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module playback_volume_pdm_config_tb import pvc_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, sel = 1'b0, role = 1'b0, fam = 1'b0, tick = 1'b0;
  logic en = 1'b1, fall = 1'b0, ck_in, ck_out, oe_n, dpin, pull, ss, sync, b44, crole, muted, pbv, snv;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, gain, pbw, snw, word = 8'h1D;
  logic [1:0] rate;
  int miscompares = 0, comparisons = 0, pbn = 0, snn = 0;
  logic [7:0] tp[5] = '{8'h00, 8'hC9, 8'hC8, 8'hFF, 8'h01};
  logic [7:0] tq[5] = '{8'hC8, 8'h00, 8'hFF, 8'hC9, 8'h7F};
  logic [1:0] rr[3] = '{RAMP_EVERY1, RAMP_EVERY4, RAMP_EVERY8};
  int nn[3] = '{1, 4, 8};

  initial forever #25 clk = ~clk;

  pvc_playback_cfg uut (.clk(clk), .reset(reset), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .playback_source_sel(sel), .pdm_pin_role(role), .rate_family_sel(fam), .sample_tick(tick),
    .pdm_clock_pin_in(ck_in), .pdm_clock_pin_out(ck_out), .pdm_clock_pin_oe_n(oe_n), .pdm_data_pin(dpin),
    .irq_pin_pullup_en(pull), .spread_spectrum_en(ss), .output_stage_audio_sync(sync), .audio_base_44k1(b44),
    .pdm_in_rate_sel(rate), .pdm_clock_role(crole), .applied_gain_code(gain), .path_muted(muted),
    .playback_pdm_word(pbw), .playback_pdm_valid(pbv), .sensor_pdm_word(snw), .sensor_pdm_valid(snv));
  pvc_pdm_src src (.en(en), .fall(fall), .word(word), .oe_n(oe_n), .pin_out(ck_out), .clk_pin(ck_in),
    .data_pin(dpin));

  always @(posedge clk) begin
    if (pbv === 1'b1) pbn++;
    if (snv === 1'b1) snn++;
  end

  // ********************
  // helpers
  // ********************
  function automatic logic [7:0] fold(input logic [7:0] c);
    return (c > VOL_MAX) ? VOL_MUTE : c;
  endfunction : fold
  // word alignment is free, so any rotation of the sent byte is accepted
  function automatic logic is_rot(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] d;
    d = {a, a};
    for (int i = 0; i < 8; i++) begin
      if (d[i +: 8] === b) return 1'b1;
    end
    return 1'b0;
  endfunction : is_rot
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  // gap cycle after each access so strobes never re-assert in one step
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    rd = 1'b1;
    addr = a;
    cyc(1);
    rd = 1'b0;
    `CHK("reg_rdata", e, rdata)
    cyc(1);
  endtask : rreg
  task automatic pulse();
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(2);
  endtask : pulse
  task automatic link(input logic [7:0] c9, input logic rl, input logic fl, input logic on);
    int p0, s0, n;
    fall = fl;
    role = rl;
    wreg(PDMCK_OFS, c9);
    `CHK("oe_n", !c9[5], oe_n)
    en = !c9[5];
    // old link setup needs two link edges to drain, a stray word may follow
    cyc(10);
    p0 = pbn;
    s0 = snn;
    n = 0;
    while (pbn + snn - p0 - s0 < 3 && n < 400) begin
      cyc(1);
      n++;
    end
    en = 1'b0;
    `CHK("words", on ? 3 : 0, pbn + snn - p0 - s0)
    `CHK("misrouted words", 0, rl ? snn - s0 : pbn - p0)
    if (on) `CHK("pdm word", 1'b1, is_rot(word, rl ? pbw : snw))
  endtask : link
  task automatic mper(input logic [7:0] r8, input logic [3:0] half);
    int n;
    wreg(SYNC_OFS, r8);
    link(8'h2A, 1'b1, 1'b0, 1'b1);
    n = 0;
    while (ck_out === 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    while (ck_out === 1'b0 && n < 40) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (ck_out === 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    `CHK("master half period", half, 4'(n))
  endtask : mper
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    #(20000 * 50);
    miscompares++;
    final_report();
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    logic [7:0] d7, d8, d9, a, b;
    void'($urandom(32'h2f24));
    cyc(12);
    reset = 1'b0;
    en = 1'b0;
    rreg(PCM_VOL_OFS, 8'h00);
    rreg(PDM_VOL_OFS, 8'h00);
    rreg(MISC_OFS, 8'h06);
    rreg(SYNC_OFS, 8'h00);
    rreg(PDMCK_OFS, 8'h08);
    for (int i = 0; i < 6; i++) begin
      d7 = 8'($urandom);
      d8 = 8'($urandom) & 8'hF7; // reserved rates never written
      d9 = 8'($urandom);
      fam = 1'($urandom);
      wreg(MISC_OFS, d7);
      wreg(SYNC_OFS, d8);
      wreg(PDMCK_OFS, d9);
      `CHK("pullup", d7[3], pull)
      `CHK("spread", d7[2], ss)
      `CHK("sync", d8[6], sync)
      `CHK("rate", d8[3:2], rate)
      `CHK("base 44k1", d8[6] & fam, b44)
      `CHK("role", d9[5], crole)
      rreg(MISC_OFS, d7);
      rreg(SYNC_OFS, d8);
    end
    wreg(8'h0A, 8'hFF);
    rreg(8'h0A, 8'h00);
    rreg(PDMCK_OFS, d9);
    wreg(MISC_OFS, 8'hC6); // ramp off
    for (int i = 0; i < 6; i++) begin
      a = (i < 5) ? tp[i] : 8'($urandom);
      b = (i < 5) ? tq[i] : 8'($urandom);
      wreg(PCM_VOL_OFS, a);
      wreg(PDM_VOL_OFS, b);
      rreg(PDM_VOL_OFS, b);
      for (int s = 0; s < 2; s++) begin
        sel = s[0];
        cyc(3);
        `CHK("gain", fold(s ? b : a), gain)
        `CHK("muted", fold(s ? b : a) == VOL_MUTE, muted)
      end
    end
    sel = 1'b0;
    wreg(PCM_VOL_OFS, 8'h00);
    cyc(3);
    for (int j = 0; j < 3; j++) begin
      wreg(MISC_OFS, {rr[j], 6'h06});
      wreg(PCM_VOL_OFS, 8'h02);
      for (int k = 1; k <= 2 * nn[j]; k++) begin
        pulse();
        `CHK("ramp gain", 8'(k / nn[j]), gain)
      end
      wreg(MISC_OFS, 8'hC6);
      wreg(PCM_VOL_OFS, 8'h00);
      cyc(2);
    end
    wreg(MISC_OFS, 8'h06);
    wreg(PCM_VOL_OFS, 8'hF0);
    repeat (200) pulse();
    `CHK("gain", VOL_MAX, gain)
    `CHK("muted", 1'b0, muted)
    pulse();
    `CHK("gain", VOL_MUTE, gain)
    `CHK("muted", 1'b1, muted)
    link(8'h0A, 1'b1, 1'b0, 1'b1);
    link(8'h8A, 1'b0, 1'b1, 1'b1);
    link(8'h08, 1'b1, 1'b0, 1'b0);
    link(8'h02, 1'b1, 1'b0, 1'b0);
    mper(8'h00, HALF_LOW);
    mper(8'h04, HALF_HIGH);
    wreg(PDMCK_OFS, 8'h08);
    `CHK("clock pin idle", 1'b0, ck_out)
    `CHK("oe_n idle", 1'b1, oe_n)
    final_report();
  end
endmodule : playback_volume_pdm_config_tb

// File: bench/pvc_pdm_src.sv
`timescale 1ns/1ps
// ********************
// pdm source model
// ********************
module pvc_pdm_src (
  // bench control
  input wire logic en,
  input wire logic fall,
  input wire logic [7:0] word,
  // device clock pin
  input wire logic oe_n,
  input wire logic pin_out,
  // link lines
  output logic clk_pin,
  output logic data_pin
);
  logic own = 1'b0;
  logic bitv = 1'b0;
  int idx = 0;
  // clock runs only while en is high, parks low once it drops
  initial begin
    #7;
    forever begin
      wait (en === 1'b1);
      #24 own = 1'b1;
      #24 own = 1'b0;
    end
  end
  // own clock only while the device is slave
  assign clk_pin = (oe_n === 1'b0) ? pin_out : own;
  // launch on the far edge, spoil after hold so a wrong-edge capture shows
  initial data_pin = 1'b0;
  always @(clk_pin) begin
    if (clk_pin === fall) begin
      bitv = word[7 - idx];
      data_pin <= bitv;
      idx = (idx + 1) % 8;
    end else begin
      data_pin <= #2 ~bitv;
    end
  end
endmodule : pvc_pdm_src

// File: core/pvc_pdm_link.sv
`timescale 1ns/1ps
module pvc_pdm_link import pvc_pkg::*; (
  // system side
  input wire logic clk,
  input wire logic reset,
  input pvc_link_cfg_t cfg,
  output logic [7:0] word_r,
  output logic word_valid_r,
  // link side
  input wire logic link_clk,
  input wire logic pdm_data_pin
);
  pvc_link_cfg_t cfg_s1, cfg_s2;
  logic rst_s1, rst_s2, fall_bit, bit_in, tog_l;
  logic tog_s1, tog_s2, tog_s3;
  logic [2:0] cnt_l;
  logic [7:0] shift_l, hold_l;

  // ****************************************
  // link domain
  // ****************************************
  always_ff @(posedge link_clk) begin
    cfg_s1 <= cfg;
    cfg_s2 <= cfg_s1;
    rst_s1 <= reset;
    rst_s2 <= rst_s1;
  end

  always_ff @(negedge link_clk) begin
    fall_bit <= pdm_data_pin;
  end

  assign bit_in = cfg_s2.capture_fall ? fall_bit : pdm_data_pin;

  // gated or grounded clock: nothing is shifted
  always_ff @(posedge link_clk) begin
    if (rst_s2 || !cfg_s2.clk_run) begin
      cnt_l <= 3'h0;
      shift_l <= 8'h00;
    end else begin
      shift_l <= {shift_l[6:0], bit_in};
      cnt_l <= cnt_l + 3'h1;
    end
  end

  // hold_l stays put for eight link cycles, well past the sync delay
  always_ff @(posedge link_clk) begin
    if (rst_s2) begin
      tog_l <= 1'b0;
      hold_l <= 8'h00;
    end else if (cfg_s2.clk_run && cnt_l == 3'h7) begin
      hold_l <= {shift_l[6:0], bit_in};
      tog_l <= ~tog_l;
    end
  end

  // ****************************************
  // system domain
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      word_r <= 8'h00;
      word_valid_r <= 1'b0;
    end else begin
      tog_s1 <= tog_l;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      word_valid_r <= tog_s2 ^ tog_s3;
      if (tog_s2 ^ tog_s3) begin
        word_r <= hold_l;
      end
    end
  end
endmodule : pvc_pdm_link

// File: core/pvc_pkg.sv
package pvc_pkg;
  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] PCM_VOL_OFS = 8'h05;
  localparam logic [7:0] PDM_VOL_OFS = 8'h06;
  localparam logic [7:0] MISC_OFS = 8'h07;
  localparam logic [7:0] SYNC_OFS = 8'h08;
  localparam logic [7:0] PDMCK_OFS = 8'h09;
  localparam logic [7:0] PCM_VOL_RST = 8'h00;
  localparam logic [7:0] PDM_VOL_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h06;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam logic [7:0] PDMCK_RST = 8'h08;
  localparam logic [7:0] RDATA_RST = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int RAMP_LSB = 6;
  localparam int PULLUP_BIT = 3;
  localparam int SS_BIT = 2;
  localparam int SYNC_BIT = 6;
  localparam int RATE_LSB = 2;
  localparam int EDGE_BIT = 7;
  localparam int ROLE_BIT = 5;
  localparam int CKSEL_BIT = 3;
  localparam int GATE_BIT = 1;
  // ****************************************
  // volume and ramp codes
  // ****************************************
  localparam logic [7:0] VOL_MAX = 8'hC8;
  localparam logic [7:0] VOL_MUTE = 8'hC9;
  localparam logic [1:0] RAMP_EVERY1 = 2'h0;
  localparam logic [1:0] RAMP_EVERY4 = 2'h1;
  localparam logic [1:0] RAMP_EVERY8 = 2'h2;
  localparam logic [1:0] RAMP_OFF = 2'h3;
  localparam logic [3:0] STEP_1 = 4'h1;
  localparam logic [3:0] STEP_4 = 4'h4;
  localparam logic [3:0] STEP_8 = 4'h8;
  // ****************************************
  // pdm clock timing
  // ****************************************
  localparam logic [1:0] RATE_LOW = 2'h0;
  localparam logic [1:0] RATE_HIGH = 2'h1;
  localparam int CLK_HZ = 20_000_000;
  localparam int RATE_LOW_MAX_HZ = 3_380_000;
  localparam int RATE_HIGH_MAX_HZ = 6_760_000;
  localparam logic [3:0] HALF_LOW = 4'((CLK_HZ + 2 * RATE_LOW_MAX_HZ - 1) / (2 * RATE_LOW_MAX_HZ));
  localparam logic [3:0] HALF_HIGH = 4'((CLK_HZ + 2 * RATE_HIGH_MAX_HZ - 1) / (2 * RATE_HIGH_MAX_HZ));
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic capture_fall;
    logic clk_run;
  } pvc_link_cfg_t;
  typedef struct packed {
    logic [1:0] rate;
    logic [7:0] target;
  } pvc_ramp_cfg_t;

  function automatic logic [3:0] ramp_steps(input logic [1:0] rate);
    return (rate == RAMP_EVERY1) ? STEP_1 : (rate == RAMP_EVERY4) ? STEP_4 : STEP_8;
  endfunction : ramp_steps

  // every mute code folds to one value above the last audible step
  function automatic logic [7:0] clamp_code(input logic [7:0] code);
    return (code > VOL_MAX) ? VOL_MUTE : code;
  endfunction : clamp_code
endpackage : pvc_pkg

// File: core/pvc_playback_cfg.sv
`timescale 1ns/1ps
module pvc_playback_cfg import pvc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // playback path control
  input wire logic playback_source_sel,
  input wire logic pdm_pin_role,
  input wire logic rate_family_sel,
  input wire logic sample_tick,
  // pdm pins
  input wire logic pdm_clock_pin_in,
  output logic pdm_clock_pin_out,
  output logic pdm_clock_pin_oe_n,
  input wire logic pdm_data_pin,
  // configuration outputs
  output logic irq_pin_pullup_en,
  output logic spread_spectrum_en,
  output logic output_stage_audio_sync,
  output logic audio_base_44k1,
  output logic [1:0] pdm_in_rate_sel,
  output logic pdm_clock_role,
  // volume
  output logic [7:0] applied_gain_code,
  output logic path_muted,
  // pdm data
  output logic [7:0] playback_pdm_word,
  output logic playback_pdm_valid,
  output logic [7:0] sensor_pdm_word,
  output logic sensor_pdm_valid
);
  logic [7:0] pcm_vol_r, pdm_vol_r, misc_r, sync_r, pdmck_r, rdata_r;
  logic [7:0] gain_r, link_word;
  logic [7:0] pb_word_r, sn_word_r;
  logic [3:0] div_cnt_r, half_cnt;
  logic link_valid, muted_r, base_r, ck_out_r, ck_oe_n_r;
  logic pb_valid_r, sn_valid_r, master_run;
  pvc_ramp_cfg_t ramp_cfg;
  pvc_link_cfg_t link_cfg;

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      pcm_vol_r <= PCM_VOL_RST;
      pdm_vol_r <= PDM_VOL_RST;
      misc_r <= MISC_RST;
      sync_r <= SYNC_RST;
      pdmck_r <= PDMCK_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        PCM_VOL_OFS: pcm_vol_r <= reg_wdata;
        PDM_VOL_OFS: pdm_vol_r <= reg_wdata;
        MISC_OFS: misc_r <= reg_wdata;
        SYNC_OFS: sync_r <= reg_wdata;
        PDMCK_OFS: pdmck_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= RDATA_RST;
    end else if (reg_rd) begin
      unique case (reg_addr)
        PCM_VOL_OFS: rdata_r <= pcm_vol_r;
        PDM_VOL_OFS: rdata_r <= pdm_vol_r;
        MISC_OFS: rdata_r <= misc_r;
        SYNC_OFS: rdata_r <= sync_r;
        PDMCK_OFS: rdata_r <= pdmck_r;
        default: rdata_r <= RDATA_RST;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // plain configuration outputs
  // ****************************************
  assign irq_pin_pullup_en = misc_r[PULLUP_BIT];
  assign spread_spectrum_en = misc_r[SS_BIT];
  assign output_stage_audio_sync = sync_r[SYNC_BIT];
  assign pdm_in_rate_sel = sync_r[RATE_LSB +: 2];
  assign pdm_clock_role = pdmck_r[ROLE_BIT];

  // family choice only counts while the output stage is locked
  always_ff @(posedge clk) begin
    if (reset) begin
      base_r <= 1'b0;
    end else begin
      base_r <= sync_r[SYNC_BIT] & rate_family_sel;
    end
  end

  assign audio_base_44k1 = base_r;

  // ****************************************
  // volume
  // ****************************************
  always_comb begin
    ramp_cfg.rate = misc_r[RAMP_LSB +: 2];
    ramp_cfg.target = clamp_code(playback_source_sel ? pdm_vol_r : pcm_vol_r);
  end

  pvc_vol_ramp u_ramp (
    .clk(clk),
    .reset(reset),
    .cfg(ramp_cfg),
    .sample_tick(sample_tick),
    .gain_r(gain_r)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      muted_r <= 1'b0;
    end else begin
      muted_r <= (gain_r == VOL_MUTE);
    end
  end

  assign applied_gain_code = gain_r;
  assign path_muted = muted_r;

  // ****************************************
  // pdm clock master
  // ****************************************
  // reserved rate codes fall back to the low band; the high band
  // lands at 5 MHz since 20 MHz divides no closer
  assign half_cnt = (pdm_in_rate_sel == RATE_HIGH) ? HALF_HIGH : HALF_LOW;
  assign master_run = pdmck_r[ROLE_BIT] & pdmck_r[CKSEL_BIT] & pdmck_r[GATE_BIT];

  always_ff @(posedge clk) begin
    if (reset || !master_run) begin
      div_cnt_r <= 4'h0;
      ck_out_r <= 1'b0;
    end else if (div_cnt_r >= half_cnt - 4'h1) begin
      div_cnt_r <= 4'h0;
      ck_out_r <= ~ck_out_r;
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  // pin is driven only as clock master
  always_ff @(posedge clk) begin
    if (reset) begin
      ck_oe_n_r <= 1'b1;
    end else begin
      ck_oe_n_r <= ~pdmck_r[ROLE_BIT];
    end
  end

  assign pdm_clock_pin_out = ck_out_r;
  assign pdm_clock_pin_oe_n = ck_oe_n_r;

  // ****************************************
  // pdm capture
  // ****************************************
  // the pin carries our own clock in master mode, so capture always
  // runs from the pin
  always_comb begin
    link_cfg.capture_fall = pdmck_r[EDGE_BIT];
    link_cfg.clk_run = pdmck_r[CKSEL_BIT] & pdmck_r[GATE_BIT];
  end

  pvc_pdm_link u_link (
    .clk(clk),
    .reset(reset),
    .cfg(link_cfg),
    .word_r(link_word),
    .word_valid_r(link_valid),
    .link_clk(pdm_clock_pin_in),
    .pdm_data_pin(pdm_data_pin)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      pb_word_r <= 8'h00;
      sn_word_r <= 8'h00;
      pb_valid_r <= 1'b0;
      sn_valid_r <= 1'b0;
    end else begin
      pb_valid_r <= link_valid & pdm_pin_role;
      sn_valid_r <= link_valid & ~pdm_pin_role;
      if (link_valid && pdm_pin_role) begin
        pb_word_r <= link_word;
      end
      if (link_valid && !pdm_pin_role) begin
        sn_word_r <= link_word;
      end
    end
  end

  assign playback_pdm_word = pb_word_r;
  assign playback_pdm_valid = pb_valid_r;
  assign sensor_pdm_word = sn_word_r;
  assign sensor_pdm_valid = sn_valid_r;

  // ****************************************
  // checks
  // ****************************************
  a_pcm_mute_path: assert property (@(posedge clk) disable iff (reset)
    (!playback_source_sel && pcm_vol_r > VOL_MAX && misc_r[RAMP_LSB +: 2] == RAMP_OFF) [*2]
    |=> path_muted)
    else $error("pcm mute code did not mute");

  a_pdm_mute_path: assert property (@(posedge clk) disable iff (reset)
    (playback_source_sel && pdm_vol_r > VOL_MAX && misc_r[RAMP_LSB +: 2] == RAMP_OFF) [*2]
    |=> path_muted)
    else $error("pdm mute code did not mute");

  a_source_volume: assert property (@(posedge clk) disable iff (reset)
    (playback_source_sel && pdm_vol_r <= VOL_MAX && misc_r[RAMP_LSB +: 2] == RAMP_OFF)
    |=> applied_gain_code == $past(pdm_vol_r))
    else $error("pdm source did not take pdm volume");

  a_pcm_volume: assert property (@(posedge clk) disable iff (reset)
    (!playback_source_sel && pcm_vol_r <= VOL_MAX && misc_r[RAMP_LSB +: 2] == RAMP_OFF)
    |=> applied_gain_code == $past(pcm_vol_r))
    else $error("pcm source did not take pcm volume");

  a_mute_from_gain: assert property (@(posedge clk) disable iff (reset)
    path_muted == ($past(applied_gain_code) == VOL_MUTE))
    else $error("mute flag does not follow gain");

  a_readback_pcm: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == PCM_VOL_OFS) |=> reg_rdata == $past(pcm_vol_r))
    else $error("pcm volume read back wrong");

  a_readback_pdm: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == PDM_VOL_OFS) |=> reg_rdata == $past(pdm_vol_r))
    else $error("pdm volume read back wrong");

  a_pullup_write: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == MISC_OFS) |=> irq_pin_pullup_en == $past(reg_wdata[PULLUP_BIT]))
    else $error("pull-up bit not taken");

  a_spread_write: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == MISC_OFS) |=> spread_spectrum_en == $past(reg_wdata[SS_BIT]))
    else $error("spread spectrum bit not taken");

  a_sync_write: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == SYNC_OFS) |=> output_stage_audio_sync == $past(reg_wdata[SYNC_BIT]))
    else $error("sync bit not taken");

  a_rate_write: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == SYNC_OFS) |=> pdm_in_rate_sel == $past(reg_wdata[RATE_LSB +: 2]))
    else $error("rate field not taken");

  a_role_write: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == PDMCK_OFS) |=> pdm_clock_role == $past(reg_wdata[ROLE_BIT]))
    else $error("clock role bit not taken");

  a_family_needs_sync: assert property (@(posedge clk) disable iff (reset)
    audio_base_44k1 |-> $past(output_stage_audio_sync))
    else $error("rate family used without sync");

  a_slave_no_drive: assert property (@(posedge clk) disable iff (reset)
    !pdm_clock_role [*2] |-> pdm_clock_pin_oe_n && !pdm_clock_pin_out)
    else $error("clock pin driven as slave");

  a_master_drives: assert property (@(posedge clk) disable iff (reset)
    pdm_clock_role [*2] |-> !pdm_clock_pin_oe_n)
    else $error("clock pin not driven as master");

  a_master_hold: assert property (@(posedge clk) disable iff (reset)
    (master_run && div_cnt_r < half_cnt - 4'h1) |=> $stable(pdm_clock_pin_out))
    else $error("master clock edge came early");

  a_master_toggle: assert property (@(posedge clk) disable iff (reset)
    (master_run && div_cnt_r >= half_cnt - 4'h1) |=> pdm_clock_pin_out != $past(pdm_clock_pin_out))
    else $error("master clock edge missing");

  a_clock_stopped: assert property (@(posedge clk) disable iff (reset)
    (!pdmck_r[CKSEL_BIT] || !pdmck_r[GATE_BIT]) |=> !pdm_clock_pin_out)
    else $error("clock ran while grounded or gated");

  a_pin_role_route: assert property (@(posedge clk) disable iff (reset)
    playback_pdm_valid |-> $past(pdm_pin_role) && !sensor_pdm_valid)
    else $error("pdm word went to the wrong sink");

  a_word_to_playback: assert property (@(posedge clk) disable iff (reset)
    playback_pdm_valid |-> playback_pdm_word == $past(link_word))
    else $error("playback word not the captured one");

  a_word_to_sensor: assert property (@(posedge clk) disable iff (reset)
    sensor_pdm_valid |-> sensor_pdm_word == $past(link_word))
    else $error("sensor word not the captured one");
endmodule : pvc_playback_cfg

// File: core/pvc_vol_ramp.sv
`timescale 1ns/1ps
module pvc_vol_ramp import pvc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input pvc_ramp_cfg_t cfg,
  input wire logic sample_tick,
  // applied gain
  output logic [7:0] gain_r
);
  logic [3:0] cnt_r;

  // ****************************************
  // gain stepping
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      gain_r <= PCM_VOL_RST;
      cnt_r <= 4'h0;
    end else if (cfg.rate == RAMP_OFF) begin
      gain_r <= cfg.target;
      cnt_r <= 4'h0;
    end else if (gain_r == cfg.target) begin
      cnt_r <= 4'h0;
    end else if (sample_tick) begin
      if (cnt_r >= ramp_steps(cfg.rate) - 4'h1) begin
        cnt_r <= 4'h0;
        // one half-dB step toward the target, mute included
        gain_r <= (gain_r < cfg.target) ? gain_r + 8'h01 : gain_r - 8'h01;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  a_ramp_off_direct: assert property (@(posedge clk) disable iff (reset)
    cfg.rate == RAMP_OFF |=> gain_r == $past(cfg.target))
    else $error("gain did not jump with ramping off");

  a_ramp_one_step: assert property (@(posedge clk) disable iff (reset)
    cfg.rate != RAMP_OFF |=> (gain_r == $past(gain_r) || gain_r == 8'($past(gain_r) + 8'h01)
      || gain_r == 8'($past(gain_r) - 8'h01)))
    else $error("gain moved more than one step");

  a_ramp_needs_tick: assert property (@(posedge clk) disable iff (reset)
    (cfg.rate != RAMP_OFF && !sample_tick) |=> gain_r == $past(gain_r))
    else $error("gain stepped without a sample");
endmodule : pvc_vol_ramp
